// ---- design/debug_match_pkg.sv ----
// constants shared by the bus comparator match block
package debug_match_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL = 6'h20;
    localparam logic [5:0] IDX_STATUS = 6'h21;
    localparam logic [5:0] IDX_SELECT = 6'h26;
    localparam logic [5:0] IDX_COMP_CTRL = 6'h28;
    localparam logic [5:0] IDX_ADDR_HIGH = 6'h29;
    localparam logic [5:0] IDX_ADDR_MID = 6'h2a;
    localparam logic [5:0] IDX_ADDR_LOW = 6'h2b;
    localparam logic [5:0] IDX_DATA_HIGH = 6'h2c;
    localparam logic [5:0] IDX_DATA_LOW = 6'h2d;
    localparam logic [5:0] IDX_MASK_HIGH = 6'h2e;
    localparam logic [5:0] IDX_MASK_LOW = 6'h2f;

    // byte address field that carries the index
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;

    // control register fields
    localparam int CTL_ARM = 0;
    localparam int CTL_BRK_EN = 1;
    // comparator control fields
    localparam int CC_ENABLE = 0;
    localparam int CC_DIR_EN = 2;
    localparam int CC_DIR = 3;
    // status register fields
    localparam int ST_ARMED = 0;
    localparam int ST_SECURE = 1;
    localparam int ST_SEEN_LSB = 4;

    // monitored bus widths and comparator count
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int NUM_COMP = 4;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- design/level_sync.sv ----
// two flip-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
`default_nettype none
module level_sync (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// ---- design/comparator_unit.sv ----
// one address and data comparator of the debug match logic
`timescale 1ns/100ps
`default_nettype none
module comparator_unit
    import debug_match_pkg::*;
#(
    parameter bit HAS_DATA = 1'b1
) (
    // stored compare values
    input wire logic [ADDR_W-1:0] cmp_addr,
    input wire logic [DATA_W-1:0] cmp_data,
    input wire logic [DATA_W-1:0] cmp_mask,
    input wire logic [7:0] cmp_ctrl,
    // monitored bus
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data,
    input wire logic bus_read,
    input wire logic bus_valid,
    // result
    output logic hit
);
    // every address bit must equal its stored bit
    wire addr_ok = (bus_addr == cmp_addr); // R1 R9 R10
    // masked-out data bits are don't care
    wire [DATA_W-1:0] data_diff = (bus_data ^ cmp_data) & cmp_mask; // R4 R5
    // comparators without data registers skip the data check
    wire data_ok = HAS_DATA ? (data_diff == '0) : 1'b1; // R2 R3 R6
    // direction checked only when enabled; 1 demands a read
    wire dir_ok = !cmp_ctrl[CC_DIR_EN] ||
        (bus_read == cmp_ctrl[CC_DIR]); // R11
    // all parts must agree within the same bus cycle
    assign hit = bus_valid && cmp_ctrl[CC_ENABLE] && addr_ok &&
        data_ok && dir_ok; // R12
endmodule
`default_nettype wire

// ---- design/debug_bus_comparator_match.sv ----
// bus comparator match logic with its axi4-lite register slave
//
// Operation
// R1: address bits 7..0 must equal the stored low address bits.
// R2: data bits 15..8 must equal the stored high data byte.
// R3: data bits 7..0 must equal the stored low data byte.
// R4: a data bit counts only when its mask bit is one.
// R5: mask bit zero excludes its data bit, one includes it.
// R6: only first and third comparators hold and compare data.
// R7: registers always readable; writes land only while not armed. Control and status writes still land while armed.
// R8: in secure mode breakpoints still occur, tracing is blocked.
// R9: address bits 22..16 must equal the stored high address bits.
// R10: address bits 15..8 must equal the stored middle address bits.
// R11: direction ignored unless enabled; then 0 write, 1 read.
// R12: match needs all address and unmasked data bits equal together.
`timescale 1ns/100ps
`default_nettype none
module debug_bus_comparator_match
    import debug_match_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // monitored core bus, same clock
    input wire logic [ADDR_W-1:0] core_address,
    input wire logic [DATA_W-1:0] core_data,
    input wire logic core_read,
    input wire logic core_cycle,
    // chip security pin, asynchronous
    input wire logic secure_mode,
    // match results
    output logic [NUM_COMP-1:0] comparator_match,
    output logic breakpoint_request,
    output logic trace_record,
    output logic armed
);
    // index decode of a byte address
    function automatic logic [5:0] reg_index(input logic [31:0] addr);
        reg_index = addr[IDX_MSB:IDX_LSB];
    endfunction

    // true when a comparator carries data registers
    function automatic logic has_data(input logic [1:0] sel);
        has_data = !sel[0];
    endfunction

    // per comparator storage
    logic [6:0] addr_high [NUM_COMP];
    logic [7:0] addr_mid [NUM_COMP];
    logic [7:0] addr_low [NUM_COMP];
    logic [7:0] comp_ctrl [NUM_COMP];
    // data storage exists only for comparators 0 and 2
    logic [7:0] data_high [2];
    logic [7:0] data_low [2];
    logic [7:0] mask_high [2];
    logic [7:0] mask_low [2];

    // global control
    logic brk_enable;
    logic [1:0] select;
    logic [NUM_COMP-1:0] match_seen;
    logic secure_sync;

    // axi bookkeeping
    logic [31:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic [31:0] rd_addr;
    logic rd_pending;

    // raw comparator results
    logic [NUM_COMP-1:0] raw_hit;

    level_sync u_secure_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(secure_mode),
        .sync_out(secure_sync)
    );

    // four comparators; only even ones compare data values
    genvar g;
    generate
        for (g = 0; g < NUM_COMP; g = g + 1) begin : g_comp
            localparam bit WITH_DATA = ((g % 2) == 0);
            localparam int DSLOT = g / 2;
            comparator_unit #(
                .HAS_DATA(WITH_DATA)
            ) u_comp (
                .cmp_addr({addr_high[g], addr_mid[g], addr_low[g]}),
                .cmp_data({data_high[DSLOT], data_low[DSLOT]}),
                .cmp_mask({mask_high[DSLOT], mask_low[DSLOT]}),
                .cmp_ctrl(comp_ctrl[g]),
                .bus_addr(core_address),
                .bus_data(core_data),
                .bus_read(core_read),
                .bus_valid(core_cycle),
                .hit(raw_hit[g])
            );
        end
    endgenerate

    // write side decode
    wire aw_taken = s_axi_awvalid && s_axi_awready;
    wire w_taken = s_axi_wvalid && s_axi_wready;
    wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [5:0] wr_idx = reg_index(wr_addr);
    wire [0:0] wr_slot = select[1];
    wire wr_has_data = has_data(select);
    wire wr_is_comp = (wr_idx >= IDX_COMP_CTRL) &&
        (wr_idx <= IDX_MASK_LOW);
    wire wr_is_data = (wr_idx >= IDX_DATA_HIGH) &&
        (wr_idx <= IDX_MASK_LOW);
    wire wr_known = wr_is_comp || (wr_idx == IDX_CONTROL) ||
        (wr_idx == IDX_STATUS) || (wr_idx == IDX_SELECT);
    // comparator registers frozen while armed; odd ones lack data
    wire wr_open = wr_fire && wr_lane && !armed; // R7
    wire wr_comp_ok = wr_open && wr_is_comp &&
        (!wr_is_data || wr_has_data); // R6
    wire wr_ctl = wr_fire && wr_lane && (wr_idx == IDX_CONTROL);
    wire wr_clr = wr_fire && wr_lane && (wr_idx == IDX_STATUS);
    wire wr_sel = wr_open && (wr_idx == IDX_SELECT);

    // read side decode
    wire ar_taken = s_axi_arvalid && s_axi_arready;
    wire r_done = s_axi_rvalid && s_axi_rready;
    wire [5:0] rd_idx = reg_index(rd_addr);
    wire [0:0] rd_slot = select[1];
    wire rd_has_data = has_data(select);
    wire [7:0] rd_status = {match_seen, 2'b00, secure_sync, armed};
    wire [7:0] rd_control = {6'b00_0000, brk_enable, armed};
    wire [7:0] rd_data_high = rd_has_data ? data_high[rd_slot] : RESET_BYTE;
    wire [7:0] rd_data_low = rd_has_data ? data_low[rd_slot] : RESET_BYTE;
    wire [7:0] rd_mask_high = rd_has_data ? mask_high[rd_slot] : RESET_BYTE;
    wire [7:0] rd_mask_low = rd_has_data ? mask_low[rd_slot] : RESET_BYTE;

    // read data selection, readable regardless of arming
    logic [7:0] rd_byte;
    logic rd_known;
    always_comb begin
        rd_byte = RESET_BYTE;
        rd_known = 1'b1;
        unique case (rd_idx)
            IDX_CONTROL: rd_byte = rd_control;
            IDX_STATUS: rd_byte = rd_status;
            IDX_SELECT: rd_byte = {6'b00_0000, select};
            IDX_COMP_CTRL: rd_byte = comp_ctrl[select];
            IDX_ADDR_HIGH: rd_byte = {1'b0, addr_high[select]}; // R7
            IDX_ADDR_MID: rd_byte = addr_mid[select];
            IDX_ADDR_LOW: rd_byte = addr_low[select];
            IDX_DATA_HIGH: rd_byte = rd_data_high;
            IDX_DATA_LOW: rd_byte = rd_data_low;
            IDX_MASK_HIGH: rd_byte = rd_mask_high;
            IDX_MASK_LOW: rd_byte = rd_mask_low;
            default: rd_known = 1'b0;
        endcase
    end

    // write address channel; held until the response completes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            wr_addr <= RESET_WORD;
        end else if (aw_taken) begin
            s_axi_awready <= 1'b0;
            wr_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel; only the low byte lane carries a register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            wr_byte <= RESET_BYTE;
            wr_lane <= 1'b0;
        end else if (w_taken) begin
            s_axi_wready <= 1'b0;
            wr_byte <= s_axi_wdata[7:0];
            wr_lane <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response; unmapped indices answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read address channel, one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            rd_addr <= RESET_WORD;
            rd_pending <= 1'b0;
        end else if (ar_taken) begin
            s_axi_arready <= 1'b0;
            rd_addr <= s_axi_araddr;
            rd_pending <= 1'b1;
        end else begin
            rd_pending <= 1'b0;
            if (r_done) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // read data channel, byte in the low lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= RESET_WORD;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_pending) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (r_done) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // arming and breakpoint enable stay writable to allow disarm
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
            brk_enable <= 1'b0;
        end else if (wr_ctl) begin
            armed <= wr_byte[CTL_ARM];
            brk_enable <= wr_byte[CTL_BRK_EN];
        end
    end

    // comparator selection, frozen with the rest while armed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            select <= 2'b00;
        end else if (wr_sel) begin
            select <= wr_byte[1:0]; // R7
        end
    end

    // address and control storage of the selected comparator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_COMP; i++) begin
                addr_high[i] <= RESET_BYTE[6:0];
                addr_mid[i] <= RESET_BYTE;
                addr_low[i] <= RESET_BYTE;
                comp_ctrl[i] <= RESET_BYTE;
            end
        end else if (wr_comp_ok) begin
            if (wr_idx == IDX_COMP_CTRL) begin
                comp_ctrl[select] <= wr_byte;
            end
            if (wr_idx == IDX_ADDR_HIGH) begin
                addr_high[select] <= wr_byte[6:0]; // R9
            end
            if (wr_idx == IDX_ADDR_MID) begin
                addr_mid[select] <= wr_byte; // R10
            end
            if (wr_idx == IDX_ADDR_LOW) begin
                addr_low[select] <= wr_byte; // R1
            end
        end
    end

    // data and mask storage; writes for odd comparators are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 2; i++) begin
                data_high[i] <= RESET_BYTE;
                data_low[i] <= RESET_BYTE;
                mask_high[i] <= RESET_BYTE;
                mask_low[i] <= RESET_BYTE;
            end
        end else if (wr_comp_ok && wr_is_data) begin
            if (wr_idx == IDX_DATA_HIGH) begin
                data_high[wr_slot] <= wr_byte; // R2
            end
            if (wr_idx == IDX_DATA_LOW) begin
                data_low[wr_slot] <= wr_byte; // R3
            end
            if (wr_idx == IDX_MASK_HIGH) begin
                mask_high[wr_slot] <= wr_byte; // R5
            end
            if (wr_idx == IDX_MASK_LOW) begin
                mask_low[wr_slot] <= wr_byte; // R5
            end
        end
    end

    // match outputs only count while armed
    wire [NUM_COMP-1:0] armed_hit = raw_hit & {NUM_COMP{armed}};
    wire any_hit = |armed_hit;
    // write-one-to-clear mask for the sticky flags
    wire [NUM_COMP-1:0] seen_clr = wr_clr ?
        wr_byte[ST_SEEN_LSB +: NUM_COMP] : {NUM_COMP{1'b0}};

    // sticky match flags; a new hit beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_seen <= {NUM_COMP{1'b0}};
        end else begin
            match_seen <= (match_seen & ~seen_clr) | armed_hit;
        end
    end

    // registered results toward sequencer, breakpoint and trace
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comparator_match <= {NUM_COMP{1'b0}};
            breakpoint_request <= 1'b0;
            trace_record <= 1'b0;
        end else begin
            comparator_match <= armed_hit; // R12
            // breakpoints survive secure mode
            breakpoint_request <= any_hit && brk_enable; // R8
            // tracing is suppressed while the chip is secured
            trace_record <= any_hit && !secure_sync; // R8
        end
    end
endmodule
`default_nettype wire

// ---- sim/debug_match_monitor.sv ----
// assertions on the ports of the bus comparator match block
`timescale 1ns/100ps
`default_nettype none
module debug_match_monitor
    import debug_match_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // core bus, pin and results
    input wire logic core_cycle,
    input wire logic secure_mode,
    input wire logic [NUM_COMP-1:0] comparator_match,
    input wire logic breakpoint_request,
    input wire logic trace_record,
    input wire logic armed
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // results lag the bus cycle by one clock and need arming
    AST_DISARMED_QUIET: assert property (
        !armed |=> comparator_match == '0)
        else $error("comparator hit while disarmed");
    AST_IDLE_QUIET: assert property (
        !core_cycle |=> comparator_match == '0 && !trace_record)
        else $error("hit without a bus cycle");
    // three samples cover the two-flop sync on the pin
    AST_SECURE_NO_TRACE: assert property (
        secure_mode [*3] |=> !trace_record)
        else $error("trace recorded in secure mode");
    AST_BRK_NEEDS_HIT: assert property (
        breakpoint_request |-> comparator_match != '0)
        else $error("breakpoint without a hit");
    AST_TRACE_NEEDS_HIT: assert property (
        trace_record |-> comparator_match != '0)
        else $error("trace without a hit");
    // read answer is fixed two clocks after the address is taken
    AST_READ_TWO: assert property (
        s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read answer not two clocks late");
    AST_READ_SINGLE: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken while answering");
    AST_WRITE_SINGLE: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule
`default_nettype wire

// ---- sim/core_bus_model.sv ----
// behavioural model of the monitored core bus
`timescale 1ns/100ps
`default_nettype none
module core_bus_model
    import debug_match_pkg::*;
(
    // clock
    input wire logic aclk,
    // bus toward the block
    output logic [ADDR_W-1:0] core_address,
    output logic [DATA_W-1:0] core_data,
    output logic core_read,
    output logic core_cycle
);
    initial begin
        core_address = '0;
        core_data = '0;
        core_read = 1'b0;
        core_cycle = 1'b0;
    end

    // one bus cycle; afterwards lines show the inverse, never stale data
    task automatic cycle(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic rd);
        @(posedge aclk);
        core_address <= a;
        core_data <= d;
        core_read <= rd;
        core_cycle <= 1'b1;
        @(posedge aclk);
        core_cycle <= 1'b0;
        core_address <= ~a;
        core_data <= ~d;
        core_read <= ~rd;
    endtask
endmodule
`default_nettype wire

// ---- sim/debug_bus_comparator_match_tb_top.sv ----
// self-checking bench for the bus comparator match block
`timescale 1ns/100ps
`default_nettype none
module debug_bus_comparator_match_tb_top
    import debug_match_pkg::*;
;
    logic aclk, aresetn, secure_mode;
    // register bus master side
    logic [31:0] awaddr, wdata, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] wstrb;
    // design and core bus model outputs
    wire logic awready, wready, bvalid, arready, rvalid, brk, trace, armed;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [ADDR_W-1:0] c_addr;
    wire logic [DATA_W-1:0] c_data;
    wire logic c_read, c_cycle;
    wire logic [NUM_COMP-1:0] match;
    // notes of expected results and shadow registers
    logic [33:0] aq[$];
    logic [6:0] mq[$];
    logic [ADDR_W-1:0] ca[4];
    logic [DATA_W-1:0] cd[4], cm[4];
    logic [7:0] cc[4];
    logic arm_s, brk_s, sec_s, cyc_d;
    logic [3:0] hits;
    int n_errors, comparisons, cycles;

    debug_bus_comparator_match u_debug_bus_comparator_match (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .core_address(c_addr), .core_data(c_data), .core_read(c_read),
        .core_cycle(c_cycle), .secure_mode(secure_mode),
        .comparator_match(match), .breakpoint_request(brk),
        .trace_record(trace), .armed(armed));
    core_bus_model u_core_bus_model (.aclk(aclk), .core_address(c_addr),
        .core_data(c_data), .core_read(c_read), .core_cycle(c_cycle));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // watcher: oldest note against each result; hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (bvalid && bready)
            check({bresp, 32'h0}, aq.pop_front());
        if (rvalid && rready)
            check({rresp, rdata}, aq.pop_front());
        if (cyc_d)
            check({27'h0, armed, trace, brk, match},
                {27'h0, mq.pop_front()});
        cyc_d <= c_cycle;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    // expected {trace, breakpoint, hits} for one core bus cycle
    function automatic logic [5:0] expect_out(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic r);
        logic [3:0] h;
        for (int n = 0; n < 4; n++) begin
            h[n] = arm_s && cc[n][0] && a === ca[n];
            h[n] &= n[0] || ((d ^ cd[n]) & cm[n]) == '0;
            h[n] &= !cc[n][2] || cc[n][3] == r;
        end
        return {|h && !sec_s, |h && brk_s, h};
    endfunction

    // write: address and data offered together, bready held
    task automatic wr(input logic [5:0] i, input logic [7:0] d,
        input logic [1:0] er = RESP_OKAY);
        aq.push_back({er, 32'h0});
        @(posedge aclk);
        awaddr <= {24'h0, i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] e,
        input logic [1:0] er = RESP_OKAY);
        aq.push_back({er, 24'h0, e});
        @(posedge aclk);
        araddr <= {24'h0, i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask

    // read back the selected comparator; high address bit 7 reads 0
    task automatic readback(input int n);
        rd(IDX_COMP_CTRL, cc[n]);
        rd(IDX_ADDR_HIGH, {1'b0, ca[n][22:16]});
        rd(IDX_ADDR_MID, ca[n][15:8]);
        rd(IDX_ADDR_LOW, ca[n][7:0]);
        rd(IDX_DATA_HIGH, cd[n][15:8]);
        rd(IDX_DATA_LOW, cd[n][7:0]);
        rd(IDX_MASK_HIGH, cm[n][15:8]);
        rd(IDX_MASK_LOW, cm[n][7:0]);
    endtask

    // odd comparators take the data writes but keep zero
    task automatic load(input int n);
        logic [31:0] v, w;
        v = $urandom;
        w = $urandom;
        ca[n] = v[22:0];
        cc[n] = {4'h0, v[24], v[23] | (n == 2), 2'b01};
        if (!n[0]) begin
            cd[n] = w[15:0];
            cm[n] = w[31:16];
        end
        wr(IDX_SELECT, n[7:0]);
        wr(IDX_COMP_CTRL, cc[n]);
        wr(IDX_ADDR_HIGH, {1'b1, ca[n][22:16]});
        wr(IDX_ADDR_MID, ca[n][15:8]);
        wr(IDX_ADDR_LOW, ca[n][7:0]);
        wr(IDX_DATA_HIGH, w[15:8]);
        wr(IDX_DATA_LOW, w[7:0]);
        wr(IDX_MASK_HIGH, w[31:24]);
        wr(IDX_MASK_LOW, w[23:16]);
        readback(n);
    endtask

    // exact hits, one flipped address or data bit, wrong direction
    task automatic burst;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic r;
        logic [5:0] e;
        int n;
        for (int k = 0; k < 40; k++) begin
            n = $urandom % 4;
            a = ca[n];
            d = (cd[n] & cm[n]) | (DATA_W'($urandom) & ~cm[n]);
            r = cc[n][3];
            case (k % 4)
                1: a[$urandom % ADDR_W] ^= 1'b1;
                2: d[$urandom % DATA_W] ^= 1'b1;
                3: r = ~r;
                default: ;
            endcase
            e = expect_out(a, d, r);
            // sticky flags collect every expected hit
            hits |= e[3:0];
            mq.push_back({arm_s, e});
            u_core_bus_model.cycle(a, d, r);
        end
    endtask

    initial begin
        aresetn = 1'b0;
        secure_mode = 1'b0;
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h1;
        {arm_s, brk_s, sec_s, hits} = '0;
        {ca[0], ca[1], ca[2], ca[3]} = '0;
        {cd[0], cd[1], cd[2], cd[3], cm[0], cm[1], cm[2], cm[3]} = '0;
        {cc[0], cc[1], cc[2], cc[3]} = '0;
        void'($urandom(63677));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and an unmapped place
        for (int i = 8'h28; i <= 8'h2f; i++) rd(6'(i), 8'h00);
        rd(6'h3f, 8'h00, RESP_SLVERR);
        wr(6'h3f, 8'h5a, RESP_SLVERR);
        for (int n = 0; n < 4; n++) load(n);
        // armed: the write is answered but must not land
        arm_s = 1'b1;
        brk_s = 1'b1;
        wr(IDX_CONTROL, 8'h03);
        rd(IDX_CONTROL, 8'h03);
        wr(IDX_ADDR_LOW, ~ca[3][7:0]);
        readback(3);
        burst();
        // secure: breakpoints stay, tracing stops
        secure_mode <= 1'b1;
        sec_s = 1'b1;
        repeat (4) @(posedge aclk);
        // sticky hits with armed and secure, then write one to clear
        rd(IDX_STATUS, {hits, 4'h3});
        wr(IDX_STATUS, {hits, 4'h0});
        rd(IDX_STATUS, 8'h03);
        burst();
        brk_s = 1'b0;
        wr(IDX_CONTROL, 8'h01);
        burst();
        secure_mode <= 1'b0;
        sec_s = 1'b0;
        arm_s = 1'b0;
        wr(IDX_CONTROL, 8'h00);
        burst();
        repeat (4) @(posedge aclk);
        print_verdict();
    end
endmodule

bind debug_bus_comparator_match debug_match_monitor u_debug_match_monitor (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .core_cycle, .secure_mode,
    .comparator_match, .breakpoint_request, .trace_record, .armed);
`default_nettype wire
